// ==== hw/multirate_fir_structures.v ====
// Multirate FIR datapath: Hilbert, zero-packed, M:1 decimator, 1:P interpolator.
// Assumes one clock, synchronous stream inputs, mode held stable while busy.
//
// Overview of operation
// - Hilbert mode turns each real input sample into one I/Q output pair.
// - The Q output comes from an odd-symmetric filter with zero taps between its non-zero ones.
// - The I output is the input delayed to the middle of the Q filter's sample history.
// - Hilbert multiplies happen only for non-zero taps, after subtracting the mirrored sample.
// - In zero-packed mode every delay element between taps holds k-1 samples.
// - Zero-packed mode emits exactly one output per accepted input.
// - Decimator subfilter i tap r uses prototype coefficient i plus M times r.
// - The decimator commutator feeds subfilters from index M-1 down to 0 and then repeats.
// - After each M inputs the decimator emits one output, the sum of all subfilter outputs.
// - Each decimator output or interpolator input uses N multiplies in total at the low rate.
// - The interpolator distributes coefficients over P subfilters with the decimator's mapping.
// - Each interpolator input feeds all P subfilters and P outputs follow in commutator order.
// - Symmetric-pair mode replaces mirrored subfilters by their coefficient sum and difference.
// - Paired subfilter outputs are added and subtracted and halved to recover the phases.
// - Interpolation by 2 with an odd symmetric tap count uses the plain subfilters.
// - Partly populated pairs get prepended zero coefficients; non-symmetric use is unpadded.
`include "fir_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module multirate_fir_structures (
  input  wire                   i_ref_clk,
  input  wire                   i_reset_n,
  input  wire [1:0]             i_mode,
  input  wire                   i_sym_pairs,
  input  wire signed [`DW-1:0]  i_in_data,
  input  wire                   i_in_valid,
  output reg                    o_in_ready,
  output reg  signed [`DW-1:0]  o_out_i,
  output reg  signed [`DW-1:0]  o_out_q,
  output reg                    o_out_valid,
  input  wire                   i_out_ready
);

  localparam S_IDLE = 2'b01;
  localparam S_EMIT = 2'b10;
  localparam PAIR_OK = !((`RATE_P == 2) && (`NTAPS % 2 == 1));

  // Symmetric Q15 prototype
  function signed [`DW-1:0] proto;
    input integer idx;
    integer m;
    begin
      m = (idx < `NTAPS / 2) ? idx : `NTAPS - 1 - idx;
      case (m)
        0:       proto = 16'sh0100;
        1:       proto = 16'sh0300;
        2:       proto = 16'sh0800;
        3:       proto = 16'sh1000;
        4:       proto = 16'sh1800;
        5:       proto = 16'sh1E00;
        default: proto = 16'sh0000;
      endcase
      if (idx < 0 || idx >= `NTAPS)
        proto = 16'sh0000;
    end
  endfunction

  // Prototype with zeros prepended for pairing
  function signed [`DW-1:0] cpad;
    input integer idx;
    begin
      cpad = (idx < `PAD) ? 16'sh0000 : proto(idx - `PAD);
    end
  endfunction

  // Non-zero Hilbert taps at odd offsets from centre
  function signed [`DW-1:0] hilb;
    input integer j;
    begin
      case (j)
        1:       hilb = 16'sh5100;
        3:       hilb = 16'sh1B00;
        5:       hilb = 16'sh1000;
        default: hilb = 16'sh0000;
      endcase
    end
  endfunction

  // Q15 product sum back to a sample word, truncating
  function signed [`DW-1:0] q15_word;
    input signed [`AW-1:0] sum;
    begin
      q15_word = sum[`OUT_SHIFT +: `DW];
    end
  endfunction

  // Commutator step: M-1 down to 0, then wrap
  function [1:0] dec_next;
    input [1:0] ph;
    begin
      if (ph == 2'h0)
        dec_next = `DEC_START;
      else
        dec_next = ph - 2'h1;
    end
  endfunction

  // Both buffer entries occupied
  function two_held;
    input head_v;
    input tail_v;
    begin
      two_held = head_v & tail_v;
    end
  endfunction

  reg signed [`DW-1:0] hist_q [0:`HLEN-1];
  reg [1:0]            state_q;
  reg [1:0]            state_d;
  reg [1:0]            mode_q;
  reg                  pairs_q;
  reg [1:0]            dec_ph_q;
  reg [1:0]            ph_q;
  reg signed [`DW-1:0] tail_i_q;
  reg signed [`DW-1:0] tail_q_q;
  reg                  tail_v_q;

  reg signed [`AW-1:0] acc;
  reg signed [`AW-1:0] acc_s;
  reg signed [`AW-1:0] acc_d;
  reg signed [`AW-1:0] qacc;
  reg signed [`DW:0]   diff;
  reg signed [`DW-1:0] res_i;
  reg signed [`DW-1:0] res_q;
  integer              i;
  integer              r;
  integer              j;
  integer              n;

  wire accept = o_in_ready & i_in_valid;
  wire pop    = o_out_valid & i_out_ready;
  wire full   = two_held(o_out_valid, tail_v_q);
  wire last_ph = (mode_q != `MODE_INT) || (ph_q == `RATE_P - 1);
  wire push   = (state_q == S_EMIT) && (!full || pop);

  // Arithmetic for the word due in the current phase
  always @* begin
    acc   = 0;
    acc_s = 0;
    acc_d = 0;
    qacc  = 0;
    diff  = 0;
    case (mode_q)
      `MODE_HIL: begin
        for (j = 1; j <= `HIL_MID; j = j + 2) begin
          diff = hist_q[`HIL_MID - j] - hist_q[`HIL_MID + j];
          qacc = qacc + hilb(j) * diff;
        end
      end
      `MODE_ZP: begin
        for (i = 0; i < `NTAPS; i = i + 1)
          acc = acc + proto(i) * hist_q[i * (`ZP_K - 1)];
      end
      `MODE_DEC: begin
        for (i = 0; i < `RATE_M; i = i + 1)
          for (r = 0; r < `NTAPS / `RATE_M; r = r + 1)
            acc = acc + proto(i + `RATE_M * r) * hist_q[i + `RATE_M * r];
      end
      default: begin
        for (r = 0; r < `NTAPS / `RATE_P; r = r + 1) begin
          acc = acc + proto(ph_q + `RATE_P * r) * hist_q[r];
          acc_s = acc_s + (cpad(`RATE_P * r) + cpad(`RATE_P - 1 + `RATE_P * r)) * hist_q[r];
          acc_d = acc_d + (cpad(`RATE_P - 1 + `RATE_P * r) - cpad(`RATE_P * r)) * hist_q[r];
        end
        if (pairs_q && PAIR_OK) begin
          if (ph_q == 2'h0)
            acc = (acc_s - acc_d) >>> 1;
          else if (ph_q == `RATE_P - 1)
            acc = (acc_s + acc_d) >>> 1;
        end
      end
    endcase
    if (mode_q == `MODE_HIL) begin
      res_i = hist_q[`HIL_MID];
      res_q = q15_word(qacc);
    end else begin
      res_i = q15_word(acc);
      res_q = 16'sh0000;
    end
  end

  // Sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (accept) begin
          if (mode_q == `MODE_DEC && dec_ph_q != 2'h0)
            state_d = S_IDLE;
          else
            state_d = S_EMIT;
        end
      end
      S_EMIT: begin
        if (push && last_ph)
          state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  // Output buffer next values
  reg                  out_v_d;
  reg                  tail_v_d;
  always @* begin
    out_v_d  = o_out_valid;
    tail_v_d = tail_v_q;
    if (pop) begin
      if (tail_v_q)
        tail_v_d = push;
      else
        out_v_d = push;
    end else if (push) begin
      if (o_out_valid)
        tail_v_d = 1'b1;
      else
        out_v_d = 1'b1;
    end
  end

  // Sample history shift register
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (n = 0; n < `HLEN; n = n + 1)
        hist_q[n] <= 16'sh0000;
    end else if (accept) begin
      hist_q[0] <= i_in_data;
      for (n = 1; n < `HLEN; n = n + 1)
        hist_q[n] <= hist_q[n - 1];
    end
  end

  // Sequencer, mode latch and commutators
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q  <= S_IDLE;
      mode_q   <= `MODE_HIL;
      pairs_q  <= 1'b0;
      dec_ph_q <= `DEC_START;
      ph_q     <= 2'h0;
    end else begin
      state_q <= state_d;
      if (state_q == S_IDLE && !accept) begin
        if (mode_q != i_mode)
          dec_ph_q <= `DEC_START;
        mode_q  <= i_mode;
        pairs_q <= i_sym_pairs;
      end
      if (accept) begin
        if (mode_q == `MODE_DEC)
          dec_ph_q <= dec_next(dec_ph_q);
        ph_q <= 2'h0;
      end else if (push && !last_ph) begin
        ph_q <= ph_q + 2'h1;
      end
    end
  end

  // Two-entry output buffer: head drives the ports, tail catches a stalled word
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_in_ready  <= 1'b0;
      o_out_valid <= 1'b0;
      o_out_i     <= 16'sh0000;
      o_out_q     <= 16'sh0000;
      tail_v_q    <= 1'b0;
      tail_i_q    <= 16'sh0000;
      tail_q_q    <= 16'sh0000;
    end else begin
      o_in_ready  <= (state_d == S_IDLE) && !two_held(out_v_d, tail_v_d);
      o_out_valid <= out_v_d;
      tail_v_q    <= tail_v_d;
      if (pop && tail_v_q) begin
        o_out_i <= tail_i_q;
        o_out_q <= tail_q_q;
      end else if (push && (!o_out_valid || pop)) begin
        o_out_i <= res_i;
        o_out_q <= res_q;
      end
      if (push && o_out_valid && (tail_v_q || !pop)) begin
        tail_i_q <= res_i;
        tail_q_q <= res_q;
      end
    end
  end

endmodule // multirate_fir_structures
`default_nettype wire

// ==== hw/fir_defines.vh ====
// Constants for the multirate filter datapath.
// Assumes inclusion by bare name from hw/ and tb/ sources.
`ifndef FIR_DEFINES_VH
`define FIR_DEFINES_VH
`define DW        16
`define AW        40
`define HLEN      24
`define NTAPS     12
`define RATE_M    3
`define RATE_P    3
`define ZP_K      3
`define HIL_MID   5
`define OUT_SHIFT 15
`define PAD       0
`define DEC_START 2'h2
`define MODE_HIL  2'h0
`define MODE_ZP   2'h1
`define MODE_DEC  2'h2
`define MODE_INT  2'h3
`endif

// ==== tb/multirate_fir_structures_assertions.sv ====
// Port checker for the multirate filter.
// Assumes the design top ports and fir_defines.vh.
`include "fir_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module multirate_fir_structures_assertions (
  input wire logic                  i_ref_clk,
  input wire logic                  i_reset_n,
  input wire logic [1:0]            i_mode,
  input wire logic                  i_in_valid,
  input wire logic                  o_in_ready,
  input wire logic signed [`DW-1:0] o_out_i,
  input wire logic signed [`DW-1:0] o_out_q,
  input wire logic                  o_out_valid,
  input wire logic                  i_out_ready
);
  wire       take;
  logic [1:0] ph_q;
  assign take = o_in_ready && i_in_valid;
  // Decimator commutator position
  always @(posedge i_ref_clk or negedge i_reset_n)
    if (!i_reset_n) ph_q <= 2'h0;
    else if (i_mode != `MODE_DEC) ph_q <= 2'h0;
    else if (take) ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  property p_hold; o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_i) && $stable(o_out_q); endproperty
  a_hold: assert property (p_hold) else $error("stalled word changed");
  property p_rst; disable iff (1'b0) !i_reset_n |-> !o_out_valid && !o_in_ready; endproperty
  a_rst: assert property (p_rst) else $error("active during reset");
  property p_q0; o_out_valid && i_mode != `MODE_HIL |-> o_out_q == 16'h0; endproperty
  a_q0: assert property (p_q0) else $error("q not zero");
  property p_drop; take && i_mode != `MODE_DEC |=> !o_in_ready; endproperty
  a_drop: assert property (p_drop) else $error("ready held after take");
  property p_intp; take && i_mode == `MODE_INT |=> !o_in_ready [*3]; endproperty
  a_intp: assert property (p_intp) else $error("interp took early");
  property p_lat; take && !i_mode[1] && !o_out_valid |-> ##[1:2] o_out_valid; endproperty
  a_lat: assert property (p_lat) else $error("no output");
  property p_ret; take && !i_mode[1] && !o_out_valid |-> ##[2:3] o_in_ready; endproperty
  a_ret: assert property (p_ret) else $error("ready not back");
  property p_decb; take && i_mode == `MODE_DEC && ph_q != 2'h2 |=> o_in_ready; endproperty
  a_decb: assert property (p_decb) else $error("decim stalled");
  property p_decq; take && i_mode == `MODE_DEC && ph_q != 2'h2 && !o_out_valid |=> !o_out_valid [*2]; endproperty
  a_decq: assert property (p_decq) else $error("early decim output");
  c_int: cover property (take && i_mode == `MODE_INT);
  c_dec: cover property (take && i_mode == `MODE_DEC && ph_q == 2'h2);
  c_stall: cover property (o_out_valid && !i_out_ready && !o_in_ready);
endmodule // multirate_fir_structures_assertions
bind multirate_fir_structures multirate_fir_structures_assertions i_chk (.i_ref_clk, .i_reset_n, .i_mode,
  .i_in_valid, .o_in_ready, .o_out_i, .o_out_q, .o_out_valid, .i_out_ready);
`default_nettype wire

// ==== tb/stream_ends.sv ====
// Sample source and stalling sink around the filter.
// Assumes the bench loads tx and sets slow.
`timescale 1ns/100ps
`default_nettype none
module stream_ends (
  input  wire logic        i_ref_clk,
  input  wire logic        i_ready,
  input  wire logic        i_valid,
  input  wire logic [15:0] i_i,
  input  wire logic [15:0] i_q,
  output var  logic        o_valid,
  output var  logic [15:0] o_data,
  output var  logic        o_ready
);
  logic [15:0] tx[$], got_i[$], got_q[$];
  logic [1:0]  cyc = 2'h0;
  logic        slow = 1'b0;
  initial begin
    o_valid = 1'b0;
    o_data = 16'h0;
    o_ready = 1'b0;
  end
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 2'h1;
    o_ready <= !slow || cyc == 2'h0;
    if (i_valid && o_ready) begin
      got_i.push_back(i_i);
      got_q.push_back(i_q);
    end
    if (o_valid && i_ready) void'(tx.pop_front());
    o_valid <= tx.size() != 0;
    // Idle data never repeats the last word
    o_data <= tx.size() != 0 ? tx[0] : ~o_data;
  end
endmodule // stream_ends
`default_nettype wire

// ==== tb/multirate_fir_structures_tb_top.sv ====
// Impulse tests of all four filter modes.
// Assumes the partner model and fir_defines.vh.
`include "fir_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module multirate_fir_structures_tb_top;
  logic        i_ref_clk = 1'b0, i_reset_n = 1'b1, i_sym_pairs = 1'b0;
  logic [1:0]  i_mode = 2'h0;
  wire  [15:0] in_data, out_i, out_q;
  wire         in_valid, in_ready, out_valid, out_ready;
  int          error_cnt = 0, check_count = 0, k, t;
  logic [15:0] c[6] = '{16'h0100, 16'h0300, 16'h0800, 16'h1000, 16'h1800, 16'h1E00};
  logic [15:0] h[3] = '{16'h5100, 16'h1B00, 16'h1000};
  logic [31:0] sum, w;
  // Mode, pairing, stall, inputs, outputs
  logic [19:0] rows[7] = '{20'hC040C, 20'hF040C, 20'h10C0C, 20'h42828, 20'h80C04, 20'h90F05, 20'h00C0C};
  always #50 i_ref_clk = ~i_ref_clk;
  multirate_fir_structures i_multirate_fir_structures (.i_ref_clk, .i_reset_n, .i_mode, .i_sym_pairs,
    .i_in_data(in_data), .i_in_valid(in_valid), .o_in_ready(in_ready), .o_out_i(out_i),
    .o_out_q(out_q), .o_out_valid(out_valid), .i_out_ready(out_ready));
  stream_ends i_stream_ends (.i_ref_clk, .i_ready(in_ready), .i_valid(out_valid), .i_i(out_i),
    .i_q(out_q), .o_valid(in_valid), .o_data(in_data), .o_ready(out_ready));
  function automatic logic [31:0] expw(input logic [1:0] m, input int k);
    int d;
    d = k - 5;
    if (m == `MODE_HIL) begin
      if (d == 0) return 32'h40000000;
      if (d[0] && d >= -5 && d <= 5) return d < 0 ? {16'h0, h[-d / 2] >> 1} : {16'h0, -(h[d / 2] >> 1)};
      return 32'h0;
    end
    if (m == `MODE_ZP) begin
      if (k[0]) return 32'h0;
      k = k / 2;
    end
    if (m == `MODE_DEC) k = 3 * k + 2;
    return k < 12 ? {c[k < 6 ? k : 11 - k] >> 1, 16'h0} : 32'h0;
  endfunction
  task chk(input logic ok, input string s);
    check_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, s);
    end
  endtask
  task conclude;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    foreach (rows[n]) begin
      @(posedge i_ref_clk);
      i_reset_n <= 1'b0;
      i_mode <= rows[n][19:18];
      i_sym_pairs <= rows[n][17];
      i_stream_ends.slow <= rows[n][16];
      repeat (5) @(posedge i_ref_clk);
      chk(out_valid === 1'b0 && in_ready === 1'b0, "reset state");
      i_reset_n <= 1'b1;
      @(negedge i_ref_clk);
      i_stream_ends.got_i.delete();
      i_stream_ends.got_q.delete();
      i_stream_ends.tx.push_back(16'h4000);
      repeat (rows[n][15:8] - 1) i_stream_ends.tx.push_back(16'h0000);
      for (t = 0; t < 3000 && i_stream_ends.got_i.size() < rows[n][7:0]; t++) @(posedge i_ref_clk);
      repeat (20) @(posedge i_ref_clk);
      chk(i_stream_ends.got_i.size() == rows[n][7:0], "output count");
      if (t == 3000) begin
        error_cnt++;
        conclude();
      end
      sum = 32'h0;
      for (k = 0; k < rows[n][7:0]; k++) begin
        w = expw(rows[n][19:18], k);
        sum = sum + {{16{i_stream_ends.got_i[k][15]}}, i_stream_ends.got_i[k]};
        chk({i_stream_ends.got_i[k], i_stream_ends.got_q[k]} === w, "sample");
      end
      if (rows[n][19:18] == `MODE_ZP) chk(sum === 32'h00005200, "packed sum");
    end
    conclude();
  end
endmodule // multirate_fir_structures_tb_top
`default_nettype wire
